// ---- hw/dmdc_pkg.sv ----
// Shared constants and types for the drive monitor display controller.
package dmdc_pkg;
	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] DMDC_OFF_CTRL = 8'h00;
	localparam logic [7:0] DMDC_OFF_STATUS = 8'h04;
	localparam logic [7:0] DMDC_OFF_CMD_COUNT = 8'h08;
	localparam logic [7:0] DMDC_OFF_FB_COUNT = 8'h0C;
	// Control register fields and reset value.
	localparam int DMDC_CTRL_MON_BIT = 0;
	localparam int DMDC_CTRL_MODE_LSB = 1;
	localparam logic [31:0] DMDC_CTRL_RESET = 32'h0000_0000;
	// Status register field positions.
	localparam int DMDC_ST_INDEX_LSB = 0;
	localparam int DMDC_ST_VALUE_BIT = 4;
	localparam int DMDC_ST_UPPER_BIT = 5;
	localparam int DMDC_ST_MON_BIT = 6;
	// Monitor index range.
	localparam logic [3:0] DMDC_IDX_FIRST = 4'h0;
	localparam logic [3:0] DMDC_IDX_LAST = 4'hD;
	// Key timing and bus response codes.
	localparam longint DMDC_CLK_HZ = 40_000_000;
	localparam longint DMDC_DATA_HOLD_MS = 1000;
	localparam longint DMDC_DATA_HOLD_CYCLES = (DMDC_DATA_HOLD_MS * DMDC_CLK_HZ + 999) / 1000;
	localparam int DMDC_TAP_CYCLES = 1;
	localparam logic [1:0] DMDC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DMDC_RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		MON_ACTUAL_SPEED = 4'h0,
		MON_SPEED_COMMAND = 4'h1,
		MON_TORQUE_COMMAND = 4'h2,
		MON_ANGLE_PULSES = 4'h3,
		MON_ELECTRICAL_ANGLE = 4'h4,
		MON_INPUT_BITS = 4'h5,
		MON_OUTPUT_BITS = 4'h6,
		MON_PULSE_SPEED = 4'h7,
		MON_POSITION_ERROR = 4'h8,
		MON_ACCUM_LOAD = 4'h9,
		MON_REGEN_LOAD = 4'hA,
		MON_BRAKE_POWER = 4'hB,
		MON_COMMAND_PULSE_COUNT = 4'hC,
		MON_FEEDBACK_PULSE_COUNT = 4'hD
	} dmdc_index_t;

	typedef enum logic [1:0] {
		CTRL_SPEED = 2'h0,
		CTRL_POSITION = 2'h1,
		CTRL_TORQUE = 2'h2
	} dmdc_ctrl_mode_t;

	typedef enum logic [2:0] {
		UNIT_INDEX = 3'h0,
		UNIT_RPM = 3'h1,
		UNIT_PERCENT = 3'h2,
		UNIT_PULSES = 3'h3,
		UNIT_DEGREES = 3'h4,
		UNIT_SEGMENTS = 3'h5,
		UNIT_REF = 3'h6,
		UNIT_HEX = 3'h7
	} dmdc_unit_t;

	// Quantities supplied by the drive's computation logic.
	typedef struct packed {
		logic [15:0] actual_speed;
		logic [15:0] speed_command;
		logic [15:0] torque_percent;
		logic [15:0] angle_pulses;
		logic [15:0] electrical_deg;
		logic [15:0] pulse_speed;
		logic [15:0] position_error;
		logic [15:0] accum_load_pct;
		logic [15:0] regen_load_pct;
		logic [15:0] brake_power_pct;
	} dmdc_status_t;

	// Sequence signal levels as seen on the connector.
	typedef struct packed {
		logic [7:0] in_levels;
		logic [6:0] out_levels;
	} dmdc_seq_t;

	// What the display shows.
	typedef struct packed {
		logic [15:0] digits;
		dmdc_unit_t unit;
		logic [7:0] segments;
		logic upper_half;
	} dmdc_display_t;
endpackage : dmdc_pkg

// ---- hw/dmdc_key.sv ----
// Keypad input conditioner: synchroniser, agreement filter and hold timer.
`timescale 1ns/100ps
`default_nettype none
module dmdc_key #(
	parameter longint HOLD_CYCLES = 1
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Key pin, active high while pressed.
	input wire logic key_pin,
	// Conditioned key.
	output logic held,
	output logic press
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic [31:0] hold_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= key_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A level change is only believed once the last two stages agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			held <= s3_reg;
		end
	end

	// One press pulse per continuous hold of HOLD_CYCLES; releasing early discards it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_reg <= 32'h0000_0000;
			press <= 1'b0;
		end else begin
			press <= 1'b0;
			if (!held) begin
				hold_reg <= 32'h0000_0000;
			end else if (hold_reg < 32'(HOLD_CYCLES)) begin
				hold_reg <= hold_reg + 32'h0000_0001;
				press <= (hold_reg == 32'(HOLD_CYCLES - 1));
			end
		end
	end
endmodule : dmdc_key
`default_nettype wire

// ---- hw/dmdc_counter.sv ----
// Up/down pulse counter with synchronous clear, wrapping at its width.
`timescale 1ns/100ps
`default_nettype none
module dmdc_counter #(
	parameter int WIDTH = 32
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Count controls.
	input wire logic count_up,
	input wire logic count_down,
	input wire logic clear,
	// Count value.
	output logic [WIDTH-1:0] count
);
	logic [WIDTH-1:0] base;
	logic [WIDTH-1:0] count_next;

	// A pulse that lands with the clear is kept, so no edge is lost.
	always_comb begin
		base = clear ? '0 : count;
		count_next = base;
		if (count_up && !count_down) begin
			count_next = base + WIDTH'(1);
		end else if (count_down && !count_up) begin
			count_next = base - WIDTH'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else begin
			count <= count_next;
		end
	end
endmodule : dmdc_counter
`default_nettype wire

// ---- hw/dmdc_monitor.sv ----
// Monitor-mode front panel controller with an AXI4-Lite register slave.
// Behaviour
// - Monitor mode is entered and used without touching motor control in any way.
// - Up or down key steps the index to next or previous entry; index shown.
// - Data key shows the selected value; pressing again returns to the index.
// - Panel data key counts only after being held continuously for one second.
// - Indices run from actual speed to feedback pulse counter, fourteen entries.
// - Torque command is shown in percent of rated torque.
// - First angle entry shows encoder pulses from the origin.
// - Second angle entry shows electrical degrees from the origin.
// - Speed command entry is offered only in speed control mode.
// - Pulse speed, position error, command counter offered only in position mode.
// - Accumulated load shows effective torque percent over a ten second window.
// - Regenerative load shows percent of processable regenerative power.
// - Brake resistor entry shows percent of processable braking power.
// - Eight input segments, each lit while its input is low.
// - Seven output segments, each lit while its output is low.
// - Both pulse counters are 32 bits and shown in hexadecimal.
// - Up or down toggles a shown counter between upper and lower halves.
// - Up and down together clear the shown 32-bit counter.
// - Undefined or unavailable indices are skipped while stepping.
`timescale 1ns/100ps
`default_nettype none
module dmdc_monitor
	import dmdc_pkg::*;
#(
	parameter longint DATA_HOLD_CYCLES = DMDC_DATA_HOLD_CYCLES
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Operator keys, high while pressed.
	input wire logic handheld_mode_key,
	input wire logic key_up,
	input wire logic key_down,
	input wire logic handheld_data_key,
	input wire logic panel_data_key,
	// Drive internal status.
	input wire dmdc_status_t drive_status,
	input wire dmdc_seq_t seq_levels,
	input wire logic cmd_pulse_up,
	input wire logic cmd_pulse_down,
	input wire logic fb_pulse_up,
	input wire logic fb_pulse_down,
	// Display.
	output dmdc_display_t display,
	output logic monitor_active
);
	logic [31:0] ctrl_reg;
	dmdc_index_t index_reg;
	logic show_value_reg;
	logic upper_reg;
	logic up_held;
	logic up_press;
	logic down_held;
	logic down_press;
	logic mode_press;
	logic hh_data_press;
	logic pn_data_press;
	logic data_press;
	logic both_keys;
	logic step_up;
	logic step_down;
	logic on_counter;
	logic clear_cmd;
	logic clear_fb;
	logic [31:0] cmd_count;
	logic [31:0] fb_count;
	logic [31:0] shown_count;
	dmdc_ctrl_mode_t ctrl_mode;
	dmdc_display_t display_next;
	logic aw_hold;
	logic w_hold;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	assign ctrl_mode = dmdc_ctrl_mode_t'(ctrl_reg[DMDC_CTRL_MODE_LSB +: 2]);

	// Whether an index exists and is offered in the present control mode.
	function automatic logic entry_visible(input logic [3:0] idx, input dmdc_ctrl_mode_t mode);
		logic ok;
		ok = (idx <= DMDC_IDX_LAST);
		case (idx)
			MON_SPEED_COMMAND: ok = (mode == CTRL_SPEED);
			MON_PULSE_SPEED, MON_POSITION_ERROR, MON_COMMAND_PULSE_COUNT: ok = (mode == CTRL_POSITION);
			default: ok = ok;
		endcase
		return ok;
	endfunction : entry_visible

	// Next visible index in the given direction, wrapping round the list.
	function automatic logic [3:0] step_index(input logic [3:0] idx, input logic dir_up, input dmdc_ctrl_mode_t mode);
		logic [3:0] cand;
		logic found;
		cand = idx;
		found = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (!found) begin
				if (dir_up) begin
					cand = (cand >= DMDC_IDX_LAST) ? DMDC_IDX_FIRST : cand + 4'h1;
				end else begin
					cand = (cand == DMDC_IDX_FIRST) ? DMDC_IDX_LAST : cand - 4'h1;
				end
				found = entry_visible(cand, mode);
			end
		end
		return found ? cand : idx;
	endfunction : step_index

	// Key conditioning: the panel data key needs a long hold, the others a tap.
	dmdc_key #(.HOLD_CYCLES(DMDC_TAP_CYCLES)) u_key_mode (
		.aclk(aclk), .aresetn(aresetn), .key_pin(handheld_mode_key), .held(), .press(mode_press));
	dmdc_key #(.HOLD_CYCLES(DMDC_TAP_CYCLES)) u_key_up (
		.aclk(aclk), .aresetn(aresetn), .key_pin(key_up), .held(up_held), .press(up_press));
	dmdc_key #(.HOLD_CYCLES(DMDC_TAP_CYCLES)) u_key_down (
		.aclk(aclk), .aresetn(aresetn), .key_pin(key_down), .held(down_held), .press(down_press));
	dmdc_key #(.HOLD_CYCLES(DMDC_TAP_CYCLES)) u_key_hh_data (
		.aclk(aclk), .aresetn(aresetn), .key_pin(handheld_data_key), .held(), .press(hh_data_press));
	dmdc_key #(.HOLD_CYCLES(DATA_HOLD_CYCLES)) u_key_pn_data (
		.aclk(aclk), .aresetn(aresetn), .key_pin(panel_data_key), .held(), .press(pn_data_press));

	assign data_press = hh_data_press || pn_data_press;
	// A press of either key while the other is already down counts as both together.
	assign both_keys = (up_press && down_held) || (down_press && up_held);
	assign step_up = up_press && !down_held;
	assign step_down = down_press && !up_held;
	assign on_counter = show_value_reg &&
		(index_reg == MON_COMMAND_PULSE_COUNT || index_reg == MON_FEEDBACK_PULSE_COUNT);
	assign clear_cmd = monitor_active && on_counter && both_keys && index_reg == MON_COMMAND_PULSE_COUNT;
	assign clear_fb = monitor_active && on_counter && both_keys && index_reg == MON_FEEDBACK_PULSE_COUNT;

	// Counters run whether or not anyone is watching them.
	dmdc_counter #(.WIDTH(32)) u_cmd_count (
		.aclk(aclk), .aresetn(aresetn), .count_up(cmd_pulse_up), .count_down(cmd_pulse_down),
		.clear(clear_cmd), .count(cmd_count));
	dmdc_counter #(.WIDTH(32)) u_fb_count (
		.aclk(aclk), .aresetn(aresetn), .count_up(fb_pulse_up), .count_down(fb_pulse_down),
		.clear(clear_fb), .count(fb_count));

	// Monitor mode only steers the display; it drives nothing toward the motor.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			monitor_active <= 1'b0;
		end else if (mode_press) begin
			monitor_active <= !monitor_active;
		end else if (aw_hold && w_hold && !s_axi_bvalid && aw_addr_reg == DMDC_OFF_CTRL && w_strb_reg[0]) begin
			monitor_active <= w_data_reg[DMDC_CTRL_MON_BIT];
		end
	end

	// Index selection and value/index toggle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			index_reg <= MON_ACTUAL_SPEED;
			show_value_reg <= 1'b0;
		end else if (!monitor_active) begin
			show_value_reg <= 1'b0;
		end else if (data_press) begin
			show_value_reg <= !show_value_reg;
		end else if (!show_value_reg && (step_up || step_down)) begin
			index_reg <= dmdc_index_t'(step_index(index_reg, step_up, ctrl_mode));
		end else if (!entry_visible(index_reg, ctrl_mode)) begin
			// A control mode change can hide the current entry; fall back to the first.
			index_reg <= MON_ACTUAL_SPEED;
			show_value_reg <= 1'b0;
		end
	end

	// Half select for counters; each value opening starts at the upper half.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upper_reg <= 1'b1;
		end else if (!on_counter) begin
			upper_reg <= 1'b1;
		end else if (step_up || step_down) begin
			upper_reg <= !upper_reg;
		end
	end

	assign shown_count = (index_reg == MON_COMMAND_PULSE_COUNT) ? cmd_count : fb_count;

	// Display content for the present state.
	always_comb begin
		display_next.digits = {12'h000, index_reg};
		display_next.unit = UNIT_INDEX;
		display_next.segments = 8'h00;
		display_next.upper_half = 1'b0;
		if (show_value_reg) begin
			case (index_reg)
				MON_ACTUAL_SPEED: begin
					display_next.digits = drive_status.actual_speed;
					display_next.unit = UNIT_RPM;
				end
				MON_SPEED_COMMAND: begin
					display_next.digits = drive_status.speed_command;
					display_next.unit = UNIT_RPM;
				end
				MON_TORQUE_COMMAND: begin
					display_next.digits = drive_status.torque_percent;
					display_next.unit = UNIT_PERCENT;
				end
				MON_ANGLE_PULSES: begin
					display_next.digits = drive_status.angle_pulses;
					display_next.unit = UNIT_PULSES;
				end
				MON_ELECTRICAL_ANGLE: begin
					display_next.digits = drive_status.electrical_deg;
					display_next.unit = UNIT_DEGREES;
				end
				MON_INPUT_BITS: begin
					display_next.digits = 16'h0000;
					display_next.unit = UNIT_SEGMENTS;
					display_next.segments = ~seq_levels.in_levels;
				end
				MON_OUTPUT_BITS: begin
					display_next.digits = 16'h0000;
					display_next.unit = UNIT_SEGMENTS;
					display_next.segments = {1'b0, ~seq_levels.out_levels};
				end
				MON_PULSE_SPEED: begin
					display_next.digits = drive_status.pulse_speed;
					display_next.unit = UNIT_RPM;
				end
				MON_POSITION_ERROR: begin
					display_next.digits = drive_status.position_error;
					display_next.unit = UNIT_REF;
				end
				MON_ACCUM_LOAD: begin
					display_next.digits = drive_status.accum_load_pct;
					display_next.unit = UNIT_PERCENT;
				end
				MON_REGEN_LOAD: begin
					display_next.digits = drive_status.regen_load_pct;
					display_next.unit = UNIT_PERCENT;
				end
				MON_BRAKE_POWER: begin
					display_next.digits = drive_status.brake_power_pct;
					display_next.unit = UNIT_PERCENT;
				end
				MON_COMMAND_PULSE_COUNT, MON_FEEDBACK_PULSE_COUNT: begin
					display_next.digits = upper_reg ? shown_count[31:16] : shown_count[15:0];
					display_next.unit = UNIT_HEX;
					display_next.upper_half = upper_reg;
				end
				default: begin
					display_next.digits = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			display <= '0;
		end else if (!monitor_active) begin
			display <= '0;
		end else begin
			display <= display_next;
		end
	end

	// AXI4-Lite write: address and data are taken in either order, response after both.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DMDC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (aw_hold && w_hold && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_reg == DMDC_OFF_CTRL) ? DMDC_RESP_OKAY : DMDC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
			end
		end
	end

	// Control register: byte lanes honoured; monitor bit is mirrored live in monitor_active.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= DMDC_CTRL_RESET;
		end else if (aw_hold && w_hold && !s_axi_bvalid && aw_addr_reg == DMDC_OFF_CTRL) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb_reg[b]) begin
					ctrl_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
				end
			end
		end
	end

	// AXI4-Lite read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= DMDC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= DMDC_RESP_OKAY;
				case (s_axi_araddr)
					DMDC_OFF_CTRL: s_axi_rdata <= {29'h0, ctrl_reg[DMDC_CTRL_MODE_LSB +: 2], monitor_active};
					DMDC_OFF_STATUS: s_axi_rdata <= {25'h0, monitor_active, upper_reg, show_value_reg, index_reg};
					DMDC_OFF_CMD_COUNT: s_axi_rdata <= cmd_count;
					DMDC_OFF_FB_COUNT: s_axi_rdata <= fb_count;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= DMDC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : dmdc_monitor
`default_nettype wire

// ---- bench/dmdc_monitor_asserts.sv ----
// Port-level assertions for the monitor controller.
`timescale 1ns/100ps
`default_nettype none
module dmdc_monitor_asserts
	import dmdc_pkg::*;
#(
	parameter longint DATA_HOLD_CYCLES = 8
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus answers.
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Panel side.
	input wire dmdc_seq_t seq_levels,
	input wire dmdc_display_t display,
	input wire logic monitor_active
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_reset_clears: assert property ($rose(aresetn) |-> !monitor_active && display == '0)
		else $error("display not dark after reset");
	// Three idle cycles allow for the display register lagging the mode flag.
	a_dark_idle: assert property (!monitor_active [*3] |-> display == '0)
		else $error("display lit outside monitor mode");
	a_seg_levels: assert property ($stable(seq_levels) [*6] ##0 display.unit == UNIT_SEGMENTS
		|-> display.segments == ~seq_levels.in_levels || display.segments == {1'b0, ~seq_levels.out_levels})
		else $error("segments do not follow low levels");
	a_half_first: assert property ($rose(display.unit == UNIT_HEX) |-> display.upper_half)
		else $error("counter did not open on upper half");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("read ready held");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > DMDC_OFF_FB_COUNT
		|=> s_axi_rresp == DMDC_RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");
	c_enter: cover property ($rose(monitor_active));
	c_lower: cover property (display.unit == UNIT_HEX && !display.upper_half);
	c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == DMDC_RESP_SLVERR);
	c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == DMDC_RESP_SLVERR);
endmodule : dmdc_monitor_asserts

bind dmdc_monitor dmdc_monitor_asserts #(.DATA_HOLD_CYCLES(DATA_HOLD_CYCLES)) i_chk (.*);
`default_nettype wire

// ---- bench/dmdc_operator.sv ----
// Operator model that presses and releases the panel and hand-held keys.
`timescale 1ns/100ps
`default_nettype none
module dmdc_operator (
	// Clock.
	input wire logic aclk,
	// Keys, high while pressed.
	output logic handheld_mode_key,
	output logic key_up,
	output logic key_down,
	output logic handheld_data_key,
	output logic panel_data_key
);
	initial {panel_data_key, handheld_data_key, key_down, key_up, handheld_mode_key} = 5'h00;
	// Patterns change only after an edge so a chord of two keys reaches the filter in one cycle.
	task automatic hold(input logic [4:0] keys, input int n);
		{panel_data_key, handheld_data_key, key_down, key_up, handheld_mode_key} <= keys;
		repeat (n) @(posedge aclk);
	endtask : hold
endmodule : dmdc_operator
`default_nettype wire

// ---- bench/dmdc_monitor_tb_top.sv ----
// Self-checking testbench for the monitor controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("wrong value %s expected %h seen %h", n, e, g); \
	end \
end
module dmdc_monitor_tb_top
	import dmdc_pkg::*;
;
	localparam int HOLD = 8;
	localparam logic [4:0] K_MODE = 5'h01;
	localparam logic [4:0] K_UP = 5'h02;
	localparam logic [4:0] K_DN = 5'h04;
	localparam logic [4:0] K_HD = 5'h08;
	localparam logic [4:0] K_PD = 5'h10;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rd;
	logic handheld_mode_key, key_up, key_down, handheld_data_key, panel_data_key;
	logic cmd_pulse_up = 1'b0, cmd_pulse_down = 1'b0, fb_pulse_up = 1'b0, fb_pulse_down = 1'b0;
	dmdc_status_t drive_status;
	dmdc_seq_t seq_levels = {8'hA5, 7'h2C};
	dmdc_display_t display;
	logic monitor_active;
	logic [3:0] cur = 4'h0;
	int num_errors = 0;
	int samples_checked = 0;
	dmdc_unit_t ut[14] = '{UNIT_RPM, UNIT_RPM, UNIT_PERCENT, UNIT_PULSES, UNIT_DEGREES, UNIT_SEGMENTS,
		UNIT_SEGMENTS, UNIT_RPM, UNIT_REF, UNIT_PERCENT, UNIT_PERCENT, UNIT_PERCENT, UNIT_HEX, UNIT_HEX};
	int fk[14] = '{0, 1, 2, 3, 4, 0, 0, 5, 6, 7, 8, 9, 0, 0};

	always #12.5 aclk = ~aclk;

	dmdc_monitor #(.DATA_HOLD_CYCLES(HOLD)) i_dut (.*);
	dmdc_operator i_op (.*);

	function automatic logic [15:0] wv(input int k);
		return 16'(16'h1357 * (k + 1));
	endfunction : wv

	function automatic logic shown(input logic [3:0] i, input logic [1:0] m);
		if (i == 4'h1) return m == CTRL_SPEED;
		if (i == 4'h7 || i == 4'h8 || i == 4'hC) return m == CTRL_POSITION;
		return i <= DMDC_IDX_LAST;
	endfunction : shown

	function automatic logic [3:0] nxt(input logic [3:0] i, input logic [1:0] m, input logic up);
		do i = up ? ((i == DMDC_IDX_LAST) ? DMDC_IDX_FIRST : i + 4'h1) : ((i == DMDC_IDX_FIRST) ? DMDC_IDX_LAST : i - 4'h1);
		while (!shown(i, m));
		return i;
	endfunction : nxt

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			pa &= !s_axi_awready;
			pw &= !s_axi_wready;
		end
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axw

	// Ready stands from the request on, so the data are taken at the edge that shows rvalid high.
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axr

	task automatic st();
		axr(DMDC_OFF_STATUS, rd, rs);
	endtask : st

	task automatic tap(input logic [4:0] m);
		i_op.hold(m, 6);
		i_op.hold(5'h00, 8);
	endtask : tap

	task automatic pulse(input logic [3:0] m, input int n);
		repeat (n) begin
			{fb_pulse_down, fb_pulse_up, cmd_pulse_down, cmd_pulse_up} <= m;
			@(posedge aclk);
			{fb_pulse_down, fb_pulse_up, cmd_pulse_down, cmd_pulse_up} <= 4'h0;
			@(posedge aclk);
		end
	endtask : pulse

	task automatic t_reset();
		`CHK("idle", 29'h0, {monitor_active, display})
		st();
		`CHK("status", 32'h0000_0020, rd)
		axr(8'h10, rd, rs);
		`CHK("unmapped", {DMDC_RESP_SLVERR, 32'h0}, {rs, rd})
		axw(DMDC_OFF_STATUS, 32'hFFFF_FFFF, rs);
		`CHK("ro write", DMDC_RESP_SLVERR, rs)
		pulse(4'h1, 3);
		pulse(4'h8, 3);
		pulse(4'h4, 1);
		axr(DMDC_OFF_CMD_COUNT, rd, rs);
		`CHK("cmd count", 32'h0000_0003, rd)
		axr(DMDC_OFF_FB_COUNT, rd, rs);
		`CHK("fb count", 32'hFFFF_FFFE, rd)
	endtask : t_reset

	task automatic t_step(input logic [1:0] m);
		axw(DMDC_OFF_CTRL, {29'h0, m, 1'b1}, rs);
		`CHK("ctrl resp", DMDC_RESP_OKAY, rs)
		axr(DMDC_OFF_CTRL, rd, rs);
		`CHK("ctrl", {29'h0, m, 1'b1}, rd)
		if (!shown(cur, m)) cur = DMDC_IDX_FIRST;
		for (int n = 0; n < 17; n++) begin
			cur = nxt(cur, m, n < 16);
			tap(n < 16 ? K_UP : K_DN);
			st();
			`CHK("index", {1'b1, cur, 12'h000, cur, UNIT_INDEX}, {rd[6], rd[3:0], display.digits, display.unit})
		end
	endtask : t_step

	task automatic t_panel();
		int n[3] = '{HOLD - 2, HOLD + 6, HOLD + 6};
		for (int k = 0; k < 3; k++) begin
			i_op.hold(K_PD, n[k]);
			i_op.hold(5'h00, 8);
			st();
			`CHK("panel open", 1'(k == 1), rd[4])
		end
	endtask : t_panel

	task automatic t_count(input int i);
		logic [31:0] v;
		logic [7:0] a;
		v = (i == 12) ? 32'h0000_0003 : 32'hFFFF_FFFE;
		a = (i == 12) ? DMDC_OFF_CMD_COUNT : DMDC_OFF_FB_COUNT;
		`CHK("upper", {1'b1, v[31:16]}, {display.upper_half, display.digits})
		tap(K_UP);
		`CHK("lower", {1'b0, v[15:0]}, {display.upper_half, display.digits})
		tap(K_DN);
		`CHK("upper again", {1'b1, v[31:16]}, {display.upper_half, display.digits})
		i_op.hold(K_UP, 6);
		i_op.hold(K_UP | K_DN, 6);
		i_op.hold(5'h00, 8);
		axr(a, rd, rs);
		`CHK("cleared", 32'h0, rd)
		pulse((i == 12) ? 4'h2 : 4'h8, 1);
		axr(a, rd, rs);
		`CHK("wrapped", 32'hFFFF_FFFF, rd)
	endtask : t_count

	task automatic t_values();
		for (int i = 0; i < 14; i++) begin
			if (!shown(4'(i), CTRL_POSITION)) continue;
			while (cur != 4'(i)) begin
				cur = nxt(cur, CTRL_POSITION, 1'b1);
				tap(K_UP);
			end
			tap(K_HD);
			st();
			`CHK("value shown", 1'b1, rd[4])
			`CHK("unit", ut[i], display.unit)
			if (i == 5) `CHK("in segs", ~seq_levels.in_levels, display.segments)
			else if (i == 6) `CHK("out segs", {1'b0, ~seq_levels.out_levels}, display.segments)
			else if (i < 12) `CHK("digits", wv(fk[i]), display.digits)
			else t_count(i);
			tap(K_HD);
			st();
			`CHK("index again", {1'b0, cur}, rd[4:0])
		end
	endtask : t_values

	task automatic finish_test();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	initial begin
		for (int k = 0; k < 10; k++) drive_status[16 * (9 - k) +: 16] = wv(k);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		tap(K_MODE);
		`CHK("monitor on", 1'b1, monitor_active)
		t_step(CTRL_SPEED);
		t_step(CTRL_TORQUE);
		t_step(CTRL_POSITION);
		t_panel();
		t_values();
		tap(K_MODE);
		`CHK("monitor off", 29'h0, {monitor_active, display})
		finish_test();
	end

	// The full sequence needs a few thousand cycles, so this limit only trips on a hang.
	initial begin
		repeat (40000) @(posedge aclk);
		num_errors++;
		finish_test();
	end
endmodule : dmdc_monitor_tb_top
`default_nettype wire
